// [hdl/thermal_monitor_map.svh]
// register offsets, field positions and reset values of the thermal monitor
`ifndef THERMAL_MONITOR_MAP_SVH
`define THERMAL_MONITOR_MAP_SVH
`define SEL_TEMPERATURE    2'h0
`define SEL_CONFIGURATION  2'h1
`define SEL_HYSTERESIS     2'h2
`define SEL_THRESHOLD      2'h3
`define CONF_SHUTDOWN_BIT  0
`define CONF_LATCH_BIT     1
`define CONF_POLARITY_BIT  2
`define CONF_QUEUE_LO_BIT  3
`define CONF_QUEUE_HI_BIT  4
`define CONF_RESET         8'h00
`define THRESHOLD_RESET    16'h5000
`define HYSTERESIS_RESET   16'h4B00
`define TEMPERATURE_RESET  11'h000
`define BUS_ADDR_FIXED     4'h9
`define BITS_PER_BYTE      4'h8
`endif

// [hdl/thermal_monitor_pkg.sv]
// types shared by the thermal monitor design
package thermal_monitor_pkg;
   typedef enum logic [8:0] {
      BUS_IDLE      = 9'h001,
      BUS_ADDR      = 9'h002,
      BUS_ADDR_ACK  = 9'h004,
      BUS_SEL       = 9'h008,
      BUS_SEL_ACK   = 9'h010,
      BUS_WDATA     = 9'h020,
      BUS_WDATA_ACK = 9'h040,
      BUS_RDATA     = 9'h080,
      BUS_RACK      = 9'h100
   } bus_state_type;
endpackage

// [hdl/thermal_monitor_register_map.sv]
// serial-bus register bank and alarm logic of a digital temperature monitor
`include "thermal_monitor_map.svh"
`timescale 1ns/10ps
`default_nettype none

module thermal_monitor_register_map
   import thermal_monitor_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_n_o,
   input  wire logic        addr_pin_2_i,
   input  wire logic        addr_pin_1_i,
   input  wire logic        addr_pin_0_i,
   input  wire logic        conv_done_i,
   input  wire logic [10:0] conv_result_i,
   output logic             conv_enable_o,
   output logic             alarm_output_o,
   output logic             alarm_output_oe_n_o
);

   // ***************************************************************
   // pin synchronisers
   // ***************************************************************
   logic [4:0]    pin_meta;
   logic [4:0]    pin_sync;
   logic          scl_prev;
   logic          sda_prev;
   logic          scl_rise;
   logic          scl_fall;
   logic          bus_start;
   logic          bus_stop;
   logic [6:0]    own_addr;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_meta <= 5'h03;
         pin_sync <= 5'h03;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         pin_meta <= {addr_pin_2_i, addr_pin_1_i, addr_pin_0_i, sda_i, scl_i};
         pin_sync <= pin_meta;
         scl_prev <= pin_sync[0];
         sda_prev <= pin_sync[1];
      end
   end

   assign scl_rise  = pin_sync[0] & ~scl_prev;
   assign scl_fall  = ~pin_sync[0] & scl_prev;
   assign bus_start = pin_sync[0] & scl_prev & sda_prev & ~pin_sync[1];
   assign bus_stop  = pin_sync[0] & scl_prev & ~sda_prev & pin_sync[1];
   assign own_addr  = {`BUS_ADDR_FIXED, pin_sync[4:2]};

   // ***************************************************************
   // registers
   // ***************************************************************
   bus_state_type state;
   logic [3:0]    bit_count;
   logic [7:0]    rx_shift;
   logic [7:0]    tx_shift;
   logic [1:0]    byte_count;
   logic          read_cmd;
   logic          sda_low;
   logic [1:0]    select;
   logic [7:0]    conf;
   logic [8:0]    threshold;
   logic [8:0]    hysteresis;
   logic [10:0]   temperature;
   logic [7:0]    next_tx;
   logic          byte_done;
   logic          write_strobe;
   logic          read_begin;
   logic          addr_match;
   logic          tx_low;

   localparam logic [15:0] THR_INIT = `THRESHOLD_RESET;
   localparam logic [15:0] HYS_INIT = `HYSTERESIS_RESET;

   assign byte_done    = scl_fall && (bit_count == `BITS_PER_BYTE);
   assign addr_match   = (rx_shift[7:1] == own_addr);
   assign write_strobe = (state == BUS_WDATA) && byte_done && (byte_count < 2'h2);
   assign read_begin   = (state == BUS_ADDR_ACK) && scl_fall && read_cmd;
   // a fresh read starts on the high byte, whatever position the last transfer left behind
   assign tx_low       = byte_count[0] && (state != BUS_ADDR_ACK);

   // byte presented to the master for the current select and byte position
   always_comb begin
      next_tx = 8'h00;
      case (select)
         `SEL_TEMPERATURE: next_tx = tx_low ? {temperature[2:0], 5'h00}
                                            : temperature[10:3];
         `SEL_CONFIGURATION: next_tx = conf;
         `SEL_HYSTERESIS: next_tx = tx_low ? {hysteresis[0], 7'h00}
                                           : hysteresis[8:1];
         default: next_tx = tx_low ? {threshold[0], 7'h00} : threshold[8:1];
      endcase
   end

   // ***************************************************************
   // bus slave sequencer
   // ***************************************************************
   // start and stop win over everything so a confused master can always recover
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state      <= BUS_IDLE;
         bit_count  <= 4'h0;
         rx_shift   <= 8'h00;
         tx_shift   <= 8'h00;
         byte_count <= 2'h0;
         read_cmd   <= 1'b0;
         sda_low    <= 1'b0;
      end else if (bus_start) begin
         state     <= BUS_ADDR;
         bit_count <= 4'h0;
         sda_low   <= 1'b0;
      end else if (bus_stop) begin
         state   <= BUS_IDLE;
         sda_low <= 1'b0;
      end else begin
         if (scl_rise && (state == BUS_ADDR || state == BUS_SEL || state == BUS_WDATA)) begin
            rx_shift  <= {rx_shift[6:0], pin_sync[1]};
            bit_count <= bit_count + 4'h1;
         end
         if (scl_rise && state == BUS_RACK) begin
            read_cmd <= ~pin_sync[1];
         end
         case (state)
            BUS_ADDR: if (byte_done) begin
               bit_count <= 4'h0;
               if (addr_match) begin
                  state    <= BUS_ADDR_ACK;
                  read_cmd <= rx_shift[0];
                  sda_low  <= 1'b1;
               end else begin
                  state <= BUS_IDLE;
               end
            end
            BUS_ADDR_ACK: if (scl_fall) begin
               byte_count <= 2'h0;
               if (read_cmd) begin
                  // no select byte: the latched one stays in force
                  state    <= BUS_RDATA;
                  tx_shift <= {next_tx[6:0], 1'b0};
                  sda_low  <= ~next_tx[7];
               end else begin
                  state   <= BUS_SEL;
                  sda_low <= 1'b0;
               end
            end
            BUS_SEL: if (byte_done) begin
               bit_count <= 4'h0;
               state     <= BUS_SEL_ACK;
               sda_low   <= 1'b1;
            end
            BUS_SEL_ACK: if (scl_fall) begin
               state   <= BUS_WDATA;
               sda_low <= 1'b0;
            end
            BUS_WDATA: if (byte_done) begin
               bit_count <= 4'h0;
               state     <= BUS_WDATA_ACK;
               sda_low   <= 1'b1;
               if (byte_count != 2'h2) begin
                  byte_count <= byte_count + 2'h1;
               end
            end
            BUS_WDATA_ACK: if (scl_fall) begin
               state   <= BUS_WDATA;
               sda_low <= 1'b0;
            end
            BUS_RDATA: if (scl_fall) begin
               if (bit_count == 4'h7) begin
                  bit_count <= 4'h0;
                  state     <= BUS_RACK;
                  sda_low   <= 1'b0;
                  byte_count <= byte_count + 2'h1;
               end else begin
                  bit_count <= bit_count + 4'h1;
                  tx_shift  <= {tx_shift[6:0], 1'b0};
                  sda_low   <= ~tx_shift[7];
               end
            end
            BUS_RACK: if (scl_fall) begin
               // master ack asks for another byte; single-byte reads end here
               if (read_cmd) begin
                  state    <= BUS_RDATA;
                  tx_shift <= {next_tx[6:0], 1'b0};
                  sda_low  <= ~next_tx[7];
               end else begin
                  state <= BUS_IDLE;
               end
            end
            default: ;
         endcase
      end
   end

   assign sda_o      = 1'b0;
   assign sda_oe_n_o = ~sda_low;

   // ***************************************************************
   // select byte and writable registers
   // ***************************************************************
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         select <= `SEL_TEMPERATURE;
      end else if (state == BUS_SEL && byte_done) begin
         select <= rx_shift[1:0];
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         conf       <= `CONF_RESET;
         threshold  <= THR_INIT[15:7];
         hysteresis <= HYS_INIT[15:7];
      end else if (write_strobe) begin
         // a write aimed at the temperature result falls through untouched
         if (select == `SEL_CONFIGURATION && byte_count == 2'h0) begin
            conf <= rx_shift;
         end else if (select == `SEL_THRESHOLD) begin
            if (byte_count == 2'h0) threshold[8:1] <= rx_shift;
            else threshold[0] <= rx_shift[7];
         end else if (select == `SEL_HYSTERESIS) begin
            if (byte_count == 2'h0) hysteresis[8:1] <= rx_shift;
            else hysteresis[0] <= rx_shift[7];
         end
      end
   end

   // ***************************************************************
   // conversion result and alarm
   // ***************************************************************
   logic          conv_accept;
   logic          shutdown;
   logic          latch_mode;
   logic          alarm;
   logic          watch_high;
   logic [2:0]    fault_count;
   logic [2:0]    queue_depth;
   logic          fault;
   logic          trip;
   logic signed [8:0] temp_top;

   assign shutdown      = conf[`CONF_SHUTDOWN_BIT];
   assign latch_mode    = conf[`CONF_LATCH_BIT];
   assign conv_enable_o = ~shutdown;
   assign conv_accept   = conv_done_i & ~shutdown;
   assign temp_top      = conv_result_i[10:2];
   assign fault         = watch_high ? (temp_top > $signed(threshold))
                                     : (temp_top < $signed(hysteresis));
   assign trip          = conv_accept && fault && ((fault_count + 3'h1) >= queue_depth);

   always_comb begin
      case (conf[`CONF_QUEUE_HI_BIT:`CONF_QUEUE_LO_BIT])
         2'h0:    queue_depth = 3'h1;
         2'h1:    queue_depth = 3'h2;
         2'h2:    queue_depth = 3'h4;
         default: queue_depth = 3'h6;
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         temperature <= `TEMPERATURE_RESET;
      end else if (conv_accept) begin
         temperature <= conv_result_i;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fault_count <= 3'h0;
         watch_high  <= 1'b1;
      end else if (conv_accept) begin
         fault_count <= (fault && !trip) ? fault_count + 3'h1 : 3'h0;
         if (trip) begin
            watch_high <= ~watch_high;
         end
      end
   end

   // a trip in the same cycle as a clearing read wins, so no event is lost
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         alarm <= 1'b0;
      end else if (trip) begin
         alarm <= latch_mode ? 1'b1 : watch_high;
      end else if (latch_mode && (read_begin || shutdown)) begin
         alarm <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         // released: the pin idles high, which is inactive at the power-up polarity
         alarm_output_oe_n_o <= 1'b1;
      end else begin
         // open drain: enable the pull-down whenever the pin level is low
         alarm_output_oe_n_o <= conf[`CONF_POLARITY_BIT] ? alarm : ~alarm;
      end
   end

   assign alarm_output_o = 1'b0;

   // ***************************************************************
   // assertions
   // ***************************************************************
   sel_latch_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state == BUS_SEL && byte_done && !bus_start && !bus_stop) |=> select == $past(rx_shift[1:0]))
      else $error("select byte not latched");
   sel_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state != BUS_SEL) |=> $stable(select))
      else $error("select changed outside select byte");
   tx_load_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (read_begin && !bus_start && !bus_stop && select == `SEL_TEMPERATURE)
      |=> sda_low == ~$past(temperature[10]) && tx_shift[7:5] == $past(temperature[9:7]))
      else $error("temperature high byte not presented");
   temp_update_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      conv_accept |=> temperature == $past(conv_result_i))
      else $error("result not refreshed");
   temp_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      shutdown |=> $stable(temperature))
      else $error("result changed in shutdown");
   temp_ro_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (write_strobe && select == `SEL_TEMPERATURE && !conv_done_i) |=> $stable(temperature))
      else $error("write reached result");
   int_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (latch_mode && read_begin && !trip) |=> !alarm)
      else $error("latched alarm not cleared by read");
   cmp_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (!latch_mode && !trip) |=> $stable(alarm))
      else $error("comparator alarm moved without trip");
   queue_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      trip |-> (fault_count == queue_depth - 3'h1))
      else $error("trip at wrong fault count");
   pin_level_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      ##1 alarm_output_oe_n_o == ($past(conf[`CONF_POLARITY_BIT]) ? $past(alarm) : ~$past(alarm)))
      else $error("alarm pin polarity wrong");
   addr_ack_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state == BUS_ADDR && byte_done && addr_match && !bus_start && !bus_stop)
      |=> state == BUS_ADDR_ACK && !sda_oe_n_o)
      else $error("own address not acknowledged");
   read_cov: cover property (@(posedge clk_i) read_begin ##[1:400] state == BUS_RACK);
   write_cov: cover property (@(posedge clk_i) write_strobe && select == `SEL_THRESHOLD);
   trip_cov: cover property (@(posedge clk_i) trip && latch_mode);

endmodule

`default_nettype wire

// [dv/bus_master_model.sv]
// two-wire bus master model that drives the monitor's serial port
`timescale 1ns/10ps
`default_nettype none

module bus_master_model (
   input  wire logic       clk_i,
   input  wire logic       sda_i,
   output logic            scl_o,
   output logic            sda_o,
   output logic [7:0]      rd_byte_o,
   output logic            rd_valid_o
);
   // ************************************************
   // bit timing: half periods of 4 clocks, 400 ns per bit
   // ************************************************
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
      rd_byte_o = 8'h00;
      rd_valid_o = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   // every ack and every kept byte is handed to the bench as a result
   task automatic note(input logic [7:0] b);
      rd_byte_o = b;
      rd_valid_o = 1'b1;
      tick(1);
      rd_valid_o = 1'b0;
   endtask

   // also serves as repeated start; clock stands high between frames
   task automatic start;
      tick(2);
      sda_o = 1'b1;
      tick(2);
      scl_o = 1'b1;
      tick(2);
      sda_o = 1'b0;
      tick(2);
      scl_o = 1'b0;
   endtask

   task automatic stop;
      tick(2);
      sda_o = 1'b0;
      tick(2);
      scl_o = 1'b1;
      tick(2);
      sda_o = 1'b1;
      tick(4);
   endtask

   // data only changes while the clock is low
   task automatic put_bit(input logic b);
      tick(2);
      sda_o = b;
      tick(2);
      scl_o = 1'b1;
      tick(4);
      scl_o = 1'b0;
   endtask

   // sample mid high phase, well after the device's 3 clock answer delay
   task automatic get_bit(output logic b);
      tick(2);
      sda_o = 1'b1;
      tick(2);
      scl_o = 1'b1;
      tick(2);
      b = sda_i;
      tick(2);
      scl_o = 1'b0;
   endtask

   task automatic send(input logic [7:0] b);
      logic a;
      for (int i = 7; i >= 0; i--) put_bit(b[i]);
      get_bit(a);
      note({7'h00, a});
   endtask

   task automatic recv(input logic last, input logic keep);
      logic [7:0] b;
      for (int i = 7; i >= 0; i--) get_bit(b[i]);
      put_bit(last);
      if (keep) note(b);
   endtask

   task automatic write_reg(input logic [6:0] addr, input logic [7:0] sel, input logic [15:0] d, input int n);
      start;
      send({addr, 1'b0});
      send(sel);
      for (int i = 0; i < n; i++) send(d[15 - 8 * i -: 8]);
      stop;
   endtask

   // without set_sel the latched select is reused
   task automatic read_reg(input logic [6:0] addr, input logic set_sel, input logic [7:0] sel, input int n,
                           input logic keep);
      if (set_sel) begin
         start;
         send({addr, 1'b0});
         send(sel);
      end
      start;
      send({addr, 1'b1});
      for (int i = 0; i < n; i++) recv(i == n - 1, keep);
      stop;
   endtask
endmodule

`default_nettype wire

// [dv/tb.sv]
// self-checking bench of the thermal monitor register bank
`include "thermal_monitor_map.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(act, exp) begin checks++; if ((act) !== (exp)) begin err_total++; \
   $display("[ERR] %0t got %h expected %h", $time, act, exp); end end

module tb;
   localparam logic [10:0] HOT  = 11'h290;
   localparam logic [10:0] COLD = 11'h100;
   logic        clk_i, reset_n_i, scl, m_sda, sda_o, sda_oe_n_o, conv_done_i, conv_enable_o;
   logic        alarm_output_o, alarm_output_oe_n_o, rd_valid;
   logic [2:0]  pins;
   logic [6:0]  addr;
   logic [10:0] conv_result_i;
   logic [7:0]  rd_byte, e;
   logic [7:0]  expq[$];
   int          err_total, checks, cycles;
   wire logic   sda_w = m_sda & (sda_oe_n_o | sda_o);

   thermal_monitor_register_map dut (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_n_o(sda_oe_n_o), .addr_pin_2_i(pins[2]), .addr_pin_1_i(pins[1]), .addr_pin_0_i(pins[0]),
      .conv_done_i(conv_done_i), .conv_result_i(conv_result_i), .conv_enable_o(conv_enable_o),
      .alarm_output_o(alarm_output_o), .alarm_output_oe_n_o(alarm_output_oe_n_o));
   bus_master_model m (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(m_sda), .rd_byte_o(rd_byte),
                       .rd_valid_o(rd_valid));

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // ************************************************
   // scoreboard and run limit
   // ************************************************
   always @(posedge clk_i) begin
      if (rd_valid === 1'b1) begin
         if (expq.size() == 0) begin
            err_total++;
            $display("[ERR] %0t result without expectation", $time);
         end else begin
            e = expq.pop_front();
            `CHK(rd_byte, e)
         end
      end
   end

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 30000) begin
         err_total++;
         $display("[ERR] %0t run limit reached", $time);
         conclude();
      end
   end

   task automatic conclude;
      if (expq.size() != 0) begin
         err_total++;
         $display("[ERR] %0t %0d expected results never arrived", $time, expq.size());
      end
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ************************************************
   // helpers
   // ************************************************
   task automatic ex(input logic [7:0] b);
      expq.push_back(b);
   endtask

   task automatic conv(input logic [10:0] r, input int n);
      repeat (n) begin
         @(negedge clk_i);
         conv_result_i = r;
         conv_done_i = 1'b1;
         @(negedge clk_i);
         conv_done_i = 1'b0;
         repeat (3) @(negedge clk_i);
      end
   endtask

   // acks of address, select and read address, then the data bytes
   task automatic rd(input logic [7:0] sel, input logic [15:0] x, input int n);
      repeat (3) ex(8'h00);
      ex(x[15:8]);
      if (n == 2) ex(x[7:0]);
      m.read_reg(addr, 1'b1, sel, n, 1'b1);
   endtask

   task automatic wr(input logic [7:0] sel, input logic [15:0] d, input int n);
      repeat (n + 2) ex(8'h00);
      m.write_reg(addr, sel, d, n);
   endtask

   task automatic pin(input logic x);
      `CHK(alarm_output_oe_n_o, x)
      `CHK(alarm_output_o, 1'b0)
   endtask

   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      logic [31:0] r;
      logic [10:0] v;
      int          d;
      r = $urandom(32'h1fe0);
      r = $urandom();
      pins = r[2:0];
      v = r[13:3];
      addr = {`BUS_ADDR_FIXED, r[2:0]};
      reset_n_i = 1'b0;
      conv_done_i = 1'b0;
      conv_result_i = 11'h000;
      err_total = 0;
      checks = 0;
      cycles = 0;
      repeat (8) @(negedge clk_i);
      reset_n_i = 1'b1;
      repeat (4) @(negedge clk_i);
      ex(8'h00);
      m.read_reg(addr, 1'b0, 8'h00, 2, 1'b0);
      conv(v, 1);
      wr(8'h00, 16'h0000, 0);
      ex(8'h00);
      ex(v[10:3]);
      ex({v[2:0], 5'h00});
      m.read_reg(addr, 1'b0, 8'h00, 2, 1'b1);
      rd(8'h00, {v[10:3], 8'h00}, 1);
      ex(8'h00);
      ex(v[10:3]);
      ex({v[2:0], 5'h00});
      m.read_reg(addr, 1'b0, 8'h00, 2, 1'b1);
      rd(8'h01, {`CONF_RESET, 8'h00}, 1);
      rd(8'h02, `HYSTERESIS_RESET, 2);
      rd(8'h03, `THRESHOLD_RESET, 2);
      ex(8'h00);
      ex(8'h50);
      ex(8'h00);
      m.read_reg(addr, 1'b0, 8'h00, 2, 1'b1);
      wr(8'h00, 16'hA5A5, 2);
      rd(8'h00, {v[10:3], v[2:0], 5'h00}, 2);
      wr(8'hFE, 16'h3CFF, 2);
      rd(8'h02, 16'h3C80, 2);
      for (int i = 0; i < 3; i++) begin
         ex(8'h01);
         ex(8'h01);
         m.write_reg(addr ^ (7'h01 << (3 * i)), 8'h01, 16'hFF00, 0);
      end
      rd(8'h01, 16'h0000, 1);
      wr(8'h01, 16'h0100, 1);
      `CHK(conv_enable_o, 1'b0)
      conv(~v, 1);
      rd(8'h00, {v[10:3], v[2:0], 5'h00}, 2);
      wr(8'h01, 16'h0000, 1);
      `CHK(conv_enable_o, 1'b1)
      conv(COLD, 1);
      conv(11'h283, 1);
      pin(1'b1);
      for (int q = 0; q < 4; q++) begin
         d = (q == 0) ? 1 : 2 * q;
         wr(8'h01, {3'h0, q[1:0], 3'h0, 8'h00}, 1);
         conv(COLD, d);
         pin(1'b1);
         conv(HOT, d - 1);
         pin(1'b1);
         conv(HOT, 1);
         pin(1'b0);
      end
      conv(COLD, 6);
      wr(8'h01, 16'h0400, 1);
      pin(1'b0);
      conv(HOT, 1);
      pin(1'b1);
      conv(COLD, 1);
      wr(8'h01, 16'h0200, 1);
      pin(1'b1);
      conv(HOT, 2);
      pin(1'b0);
      rd(8'h01, 16'h0200, 1);
      pin(1'b1);
      conv(COLD, 1);
      pin(1'b0);
      repeat (20) @(negedge clk_i);
      conclude();
   end
endmodule

`default_nettype wire
